//--- hdl/spfs_pkg.sv
// Constants and types shared by the flash sequencer and its CPU end
package spfs_pkg;
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int SPFS_WORD_W = 14;
  localparam int SPFS_ADDR_W = 15;
  localparam int SPFS_ROW_WORDS = 32;
  localparam int SPFS_LAT_W = 5;
  localparam logic [13:0] SPFS_BLANK = 14'h3FFF;
  localparam logic [14:0] SPFS_ADDR_RST = 15'h0000;
  localparam logic [13:0] SPFS_DATA_RST = 14'h0000;

  // ****************************************
  // Special function register indices
  // ****************************************
  localparam logic [2:0] SPFS_SFR_ADDR_LO = 3'h0;
  localparam logic [2:0] SPFS_SFR_ADDR_HI = 3'h1;
  localparam logic [2:0] SPFS_SFR_DATA_LO = 3'h2;
  localparam logic [2:0] SPFS_SFR_DATA_HI = 3'h3;
  localparam logic [2:0] SPFS_SFR_CTRL = 3'h4;
  localparam logic [2:0] SPFS_SFR_KEY = 3'h5;

  // Control register bit positions
  localparam int SPFS_B_RD = 0;
  localparam int SPFS_B_WR = 1;
  localparam int SPFS_B_WRITE_ALLOW = 2;
  localparam int SPFS_B_WRITE_FAULT_FLAG = 3;
  localparam int SPFS_B_FREE = 4;
  localparam int SPFS_B_LATCH_ONLY_SELECT = 5;
  localparam int SPFS_B_CONFIG_SPACE_SELECT = 6;

  // Unlock key values
  localparam logic [7:0] SPFS_KEY1 = 8'h55;
  localparam logic [7:0] SPFS_KEY2 = 8'hAA;

  // ****************************************
  // Self-timed operation length
  // ****************************************
  localparam int SPFS_CLK_MHZ = 100;
  localparam int SPFS_PROG_TIME_US = 2000;
  localparam int SPFS_PROG_CYCLES = SPFS_PROG_TIME_US * SPFS_CLK_MHZ;
  localparam int SPFS_CNT_W = 18;

  // ****************************************
  // Host software registers
  // ****************************************
  localparam logic [2:0] SPFS_H_CMD = 3'h0;
  localparam logic [2:0] SPFS_H_ADDR = 3'h1;
  localparam logic [2:0] SPFS_H_DATA = 3'h2;
  localparam logic [2:0] SPFS_H_STAT = 3'h3;
  localparam logic [2:0] SPFS_H_RDATA = 3'h4;

  typedef enum logic [1:0] {
    SPFS_OP_READ = 2'h0,
    SPFS_OP_ERASE = 2'h1,
    SPFS_OP_LOAD = 2'h2,
    SPFS_OP_PROG = 2'h3
  } spfs_op_t;

  typedef enum logic [5:0] {
    SPFS_ST_IDLE = 6'h01,
    SPFS_ST_RD_GAP = 6'h02,
    SPFS_ST_RD_ACC = 6'h04,
    SPFS_ST_NOP1 = 6'h08,
    SPFS_ST_NOP2 = 6'h10,
    SPFS_ST_BUSY = 6'h20
  } spfs_dev_st_t;

  typedef enum logic [1:0] {
    SPFS_HS_IDLE = 2'h1,
    SPFS_HS_RUN = 2'h2
  } spfs_host_st_t;
endpackage

//--- hdl/spfs_if.sv
// Instruction-side register link between CPU end and flash sequencer
`timescale 1ns/100ps
interface spfs_if;
  logic [2:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_we;
  logic sfr_re;
  logic [7:0] sfr_rdata;
  logic squash;
  logic stall;

  modport dev (
    input sfr_addr, sfr_wdata, sfr_we, sfr_re,
    output sfr_rdata, squash, stall
  );
  modport cpu (
    output sfr_addr, sfr_wdata, sfr_we, sfr_re,
    input sfr_rdata, squash, stall
  );
endinterface

//--- hdl/spfs_device.sv
// Flash self-programming sequencer with write latches and flash array
//
// Contract
// - Flash in 14-bit word rows; row erase minimum
// - Thirty-two write latches, one row
// - Latches loaded only via data register pair
// - Read steals second cycle; data next cycle
// - Data pair holds read word until overwritten
// - Software loads address, clears config, two NOPs
// - Software writes 55h, AAh, then write trigger
// - Broken key sequence blocks load and write
// - Write trigger forces next two slots NOP
// - Erase/program stall 2 ms; load never stalls
// - Clocks run; resume third instruction after
// - Row erase: address, free, allow, key, trigger
// - Programming never erases; bits only clear
// - Upper ten bits row, low five latch
// - Completion resets all latches to 3FFF
// - Latch-only loads one; else programs row
// - One to thirty-two words per program
// - Unprogrammed words programmable without erase
// - Software masks interrupts around key sequence
// - Triggers set by software, cleared by hardware
// - Reset during erase/program sets fault flag
// - Write allow clear at reset, gates writes
`timescale 1ns/100ps
module spfs_device
  import spfs_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = SPFS_PROG_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic ce_i,
  spfs_if.dev bus,
  output logic busy_o,
  output logic write_fault_o
);
  // ****************************************
  // State
  // ****************************************
  spfs_dev_st_t st_q, st_d;
  logic [14:0] addr_q;
  logic [13:0] data_q;
  logic config_space_select_q, latch_only_select_q, free_q, write_allow_q, rd_q, wr_q;
  logic fault_q, live_q;
  logic [1:0] key_q, key_d;
  logic [SPFS_CNT_W-1:0] cnt_q;
  logic [7:0] rdata_q;
  logic [13:0] latch_q [SPFS_ROW_WORDS];
  logic [13:0] flash_mem [2**SPFS_ADDR_W];

  // ****************************************
  // Access decode
  // ****************************************
  wire idle = st_q == SPFS_ST_IDLE;
  wire any_acc = bus.sfr_we || bus.sfr_re;
  wire wr_ctrl = bus.sfr_we && bus.sfr_addr == SPFS_SFR_CTRL;
  wire wr_key = bus.sfr_we && bus.sfr_addr == SPFS_SFR_KEY;
  wire wr_dlo = bus.sfr_we && bus.sfr_addr == SPFS_SFR_DATA_LO;
  wire wr_dhi = bus.sfr_we && bus.sfr_addr == SPFS_SFR_DATA_HI;
  wire wr_alo = bus.sfr_we && bus.sfr_addr == SPFS_SFR_ADDR_LO;
  wire wr_ahi = bus.sfr_we && bus.sfr_addr == SPFS_SFR_ADDR_HI;
  wire armed = key_q == 2'h2;
  wire wr_set = wr_ctrl && bus.sfr_wdata[SPFS_B_WR] && idle;
  wire rd_set = wr_ctrl && bus.sfr_wdata[SPFS_B_RD] && idle;
  // Trigger honoured only after unbroken key and write allow
  wire start = wr_set && armed && bus.sfr_wdata[SPFS_B_WRITE_ALLOW];
  wire rd_go = rd_set && !start;
  wire new_free = bus.sfr_wdata[SPFS_B_FREE];
  wire new_latch_only_select = bus.sfr_wdata[SPFS_B_LATCH_ONLY_SELECT];
  // Erase ignores latch-only; latch load happens on any non-erase start
  wire load_en = start && !new_free;
  wire long_op = free_q || !latch_only_select_q;
  wire done = st_q == SPFS_ST_BUSY && cnt_q == '0;
  wire [9:0] row = addr_q[14:5];
  wire [4:0] lat_sel = addr_q[4:0];
  wire [7:0] ctrl_rd = {1'b1, config_space_select_q, latch_only_select_q, free_q, fault_q, write_allow_q, wr_q, rd_q};
  wire [7:0] rd_mux =
    bus.sfr_addr == SPFS_SFR_ADDR_LO ? addr_q[7:0] :
    bus.sfr_addr == SPFS_SFR_ADDR_HI ? {1'b1, addr_q[14:8]} :
    bus.sfr_addr == SPFS_SFR_DATA_LO ? data_q[7:0] :
    bus.sfr_addr == SPFS_SFR_DATA_HI ? {2'b00, data_q[13:8]} :
    bus.sfr_addr == SPFS_SFR_CTRL ? ctrl_rd : 8'h00;

  // Core handshake: forced NOP slots and stall
  assign bus.squash = st_q == SPFS_ST_RD_ACC || st_q == SPFS_ST_NOP1
    || st_q == SPFS_ST_NOP2;
  assign bus.stall = st_q == SPFS_ST_BUSY;
  assign bus.sfr_rdata = rdata_q;
  assign busy_o = !idle;
  assign write_fault_o = fault_q;

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SPFS_ST_IDLE: begin
        if (start) begin
          st_d = SPFS_ST_NOP1;
        end else if (rd_go) begin
          st_d = SPFS_ST_RD_GAP;
        end
      end
      SPFS_ST_RD_GAP: st_d = SPFS_ST_RD_ACC;
      SPFS_ST_RD_ACC: st_d = SPFS_ST_IDLE;
      SPFS_ST_NOP1: st_d = SPFS_ST_NOP2;
      SPFS_ST_NOP2: st_d = long_op ? SPFS_ST_BUSY : SPFS_ST_IDLE;
      SPFS_ST_BUSY: st_d = done ? SPFS_ST_IDLE : SPFS_ST_BUSY;
    endcase
  end

  // Unlock key tracker; any other access breaks it
  always_comb begin
    key_d = key_q;
    if (wr_key && bus.sfr_wdata == SPFS_KEY1) begin
      key_d = 2'h1;
    end else if (wr_key && bus.sfr_wdata == SPFS_KEY2 && key_q == 2'h1) begin
      key_d = 2'h2;
    end else if (any_acc) begin
      key_d = 2'h0;
    end
  end

  // State, key and timer
  always_ff @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      st_q <= SPFS_ST_IDLE;
      key_q <= 2'h0;
      cnt_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      key_q <= key_d;
      if (st_q == SPFS_ST_NOP2) begin
        cnt_q <= SPFS_CNT_W'(PROG_CYCLES - 1);
      end else if (st_q == SPFS_ST_BUSY && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Address, control and trigger bits
  always_ff @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      addr_q <= SPFS_ADDR_RST;
      {config_space_select_q, latch_only_select_q, free_q, write_allow_q} <= 4'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_alo) addr_q[7:0] <= bus.sfr_wdata;
      if (wr_ahi) addr_q[14:8] <= bus.sfr_wdata[6:0];
      if (wr_ctrl && idle) begin
        config_space_select_q <= bus.sfr_wdata[SPFS_B_CONFIG_SPACE_SELECT];
        latch_only_select_q <= new_latch_only_select;
        free_q <= new_free;
        write_allow_q <= bus.sfr_wdata[SPFS_B_WRITE_ALLOW];
      end else if (done) begin
        free_q <= 1'b0;
      end
      // Triggers: software can only set, hardware clears
      if (rd_go) begin
        rd_q <= 1'b1;
      end else if (st_q == SPFS_ST_RD_ACC) begin
        rd_q <= 1'b0;
      end
      if (start) begin
        wr_q <= 1'b1;
      end else if (done || (st_q == SPFS_ST_NOP2 && !long_op)) begin
        wr_q <= 1'b0;
      end
    end
  end

  // Data pair: software bytes, or fetched word on read
  always_ff @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      data_q <= SPFS_DATA_RST;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      if (st_q == SPFS_ST_RD_ACC) begin
        data_q <= config_space_select_q ? SPFS_DATA_RST : flash_mem[addr_q];
      end else begin
        if (wr_dlo) data_q[7:0] <= bus.sfr_wdata;
        if (wr_dhi) data_q[13:8] <= bus.sfr_wdata[5:0];
      end
      if (bus.sfr_re) rdata_q <= rd_mux;
    end
  end

  // Fault flag and op marker survive ordinary reset
  always_ff @(posedge ref_clk_i or posedge por_i) begin
    if (por_i) begin
      fault_q <= 1'b0;
      live_q <= 1'b0;
    end else if (ce_i) begin
      if (live_q && idle) begin
        fault_q <= 1'b1;
      end else if (wr_ctrl && idle) begin
        fault_q <= bus.sfr_wdata[SPFS_B_WRITE_FAULT_FLAG];
      end
      if (start && (new_free || !new_latch_only_select)) begin
        live_q <= 1'b1;
      end else if (done || idle) begin
        live_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write latches
  // ****************************************
  // One row of latches, blanked on every completion
  for (genvar g = 0; g < SPFS_ROW_WORDS; g++) begin : g_lat
    always_ff @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
      if (rst_i || por_i) begin
        latch_q[g] <= SPFS_BLANK;
      end else if (ce_i) begin
        if (done) begin
          latch_q[g] <= SPFS_BLANK;
        end else if (load_en && lat_sel == SPFS_LAT_W'(g)) begin
          latch_q[g] <= data_q;
        end
      end
    end
  end

  // ****************************************
  // Flash array
  // ****************************************
  // Erase blanks whole row; program only clears bits
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && done && !config_space_select_q) begin
      for (int i = 0; i < SPFS_ROW_WORDS; i++) begin
        if (free_q) begin
          flash_mem[{row, SPFS_LAT_W'(i)}] <= SPFS_BLANK;
        end else begin
          flash_mem[{row, SPFS_LAT_W'(i)}] <=
            flash_mem[{row, SPFS_LAT_W'(i)}] & latch_q[i];
        end
      end
    end
  end
endmodule

//--- hdl/spfs_host.sv
// CPU end that runs self-programming instruction sequences on orders
`timescale 1ns/100ps
module spfs_host
  import spfs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  spfs_if.cpu bus,
  input wire logic [2:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_we_i,
  input wire logic sw_re_i,
  output logic [15:0] sw_rdata_o
);
  // ****************************************
  // State
  // ****************************************
  spfs_host_st_t st_q;
  spfs_op_t op_q;
  logic [14:0] addr_q;
  logic [13:0] wdat_q, rdat_q;
  logic [3:0] step_q;
  logic fault_q, done_q, pend_q;
  logic [2:0] psel_q;
  logic [15:0] sw_rdata_q;
  logic [1:0] s_kind;
  logic [2:0] s_addr;
  logic [7:0] s_data;
  logic s_last;

  // ****************************************
  // Instruction step table
  // ****************************************
  wire run = st_q == SPFS_HS_RUN;
  wire rd_op = op_q == SPFS_OP_READ;
  wire [7:0] cbase = {3'b000, op_q == SPFS_OP_ERASE, 1'b0, !rd_op, 2'b00}
    | {2'b00, op_q == SPFS_OP_LOAD, 5'h00};

  // Kind 0 is a NOP slot, 1 a write, 2 a read
  always_comb begin
    s_kind = 2'h1;
    s_addr = SPFS_SFR_CTRL;
    s_data = cbase;
    s_last = 1'b0;
    unique case (step_q)
      4'h0: {s_addr, s_data} = {SPFS_SFR_ADDR_LO, addr_q[7:0]};
      4'h1: {s_addr, s_data} = {SPFS_SFR_ADDR_HI, 1'b0, addr_q[14:8]};
      4'h2: {s_addr, s_data} = {SPFS_SFR_DATA_LO, wdat_q[7:0]};
      4'h3: {s_addr, s_data} = {SPFS_SFR_DATA_HI, 2'b00, wdat_q[13:8]};
      4'h4: s_data = cbase;
      4'h5: begin
        if (rd_op) s_data = cbase | 8'h01;
        else {s_addr, s_data} = {SPFS_SFR_KEY, SPFS_KEY1};
      end
      4'h6: begin
        if (rd_op) s_kind = 2'h0;
        else {s_addr, s_data} = {SPFS_SFR_KEY, SPFS_KEY2};
      end
      4'h7: begin
        if (rd_op) s_kind = 2'h0;
        else s_data = cbase | 8'h02;
      end
      4'h8: begin
        if (rd_op) {s_kind, s_addr} = {2'h2, SPFS_SFR_DATA_LO};
        else s_kind = 2'h0;
      end
      4'h9: begin
        if (rd_op) {s_kind, s_addr} = {2'h2, SPFS_SFR_DATA_HI};
        else s_kind = 2'h0;
      end
      4'hA: begin
        if (rd_op) {s_kind, s_last} = 3'h1;
        else s_kind = 2'h2;
      end
      4'hB: s_data = 8'h00;
      default: {s_kind, s_last} = 3'h1;
    endcase
  end

  // Advance when not stalled; squashed slots consume NOP steps only
  wire go = run && !bus.stall && !(bus.squash && s_kind != 2'h0);
  assign bus.sfr_we = go && s_kind == 2'h1 && !s_last;
  assign bus.sfr_re = go && s_kind == 2'h2;
  assign bus.sfr_addr = s_addr;
  assign bus.sfr_wdata = s_data;
  assign sw_rdata_o = sw_rdata_q;

  // ****************************************
  // Sequencing and capture
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= SPFS_HS_IDLE;
      op_q <= SPFS_OP_READ;
      step_q <= 4'h0;
      pend_q <= 1'b0;
      psel_q <= 3'h0;
      done_q <= 1'b0;
    end else if (ce_i) begin
      pend_q <= bus.sfr_re;
      psel_q <= s_addr;
      if (!run && sw_we_i && sw_addr_i == SPFS_H_CMD) begin
        op_q <= spfs_op_t'(sw_wdata_i[1:0]);
        st_q <= SPFS_HS_RUN;
        step_q <= 4'h0;
        done_q <= 1'b0;
      end else if (go && s_last) begin
        st_q <= SPFS_HS_IDLE;
        done_q <= 1'b1;
      end else if (go) begin
        step_q <= step_q + 1'b1;
      end
    end
  end

  // Software registers and captured read bytes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= SPFS_ADDR_RST;
      wdat_q <= SPFS_DATA_RST;
      rdat_q <= SPFS_DATA_RST;
      fault_q <= 1'b0;
      sw_rdata_q <= 16'h0000;
    end else if (ce_i) begin
      if (!run && sw_we_i && sw_addr_i == SPFS_H_ADDR) addr_q <= sw_wdata_i[14:0];
      if (!run && sw_we_i && sw_addr_i == SPFS_H_DATA) wdat_q <= sw_wdata_i[13:0];
      if (pend_q && psel_q == SPFS_SFR_DATA_LO) rdat_q[7:0] <= bus.sfr_rdata;
      if (pend_q && psel_q == SPFS_SFR_DATA_HI) rdat_q[13:8] <= bus.sfr_rdata[5:0];
      if (pend_q && psel_q == SPFS_SFR_CTRL) fault_q <= bus.sfr_rdata[SPFS_B_WRITE_FAULT_FLAG];
      if (sw_re_i) begin
        sw_rdata_q <= sw_addr_i == SPFS_H_ADDR ? {1'b0, addr_q} :
          sw_addr_i == SPFS_H_DATA ? {2'b00, wdat_q} :
          sw_addr_i == SPFS_H_STAT ? {13'h0000, fault_q, done_q, run} :
          sw_addr_i == SPFS_H_RDATA ? {2'b00, rdat_q} : 16'h0000;
      end
    end
  end
endmodule

//--- bench/spfs_chk.sv
// Concurrent checks on the link between CPU end and sequencer
`timescale 1ns/100ps
module spfs_chk
  import spfs_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = SPFS_PROG_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic [2:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_rdata,
  input wire logic squash,
  input wire logic stall,
  input wire logic busy_o
);
  // ********
  // Decodes
  // ********
  logic [31:0] cnt_q;
  wire logic [31:0] cnt_d = stall ? cnt_q + 32'h1 : 32'h0;
  wire logic ctl_we = sfr_we && sfr_addr == SPFS_SFR_CTRL;
  wire logic wr_go = ctl_we && sfr_wdata[SPFS_B_WR] && sfr_wdata[SPFS_B_WRITE_ALLOW];
  wire logic rd_go = ctl_we && sfr_wdata[SPFS_B_RD] && !sfr_wdata[SPFS_B_WR] && !busy_o;
  wire logic quick = sfr_wdata[SPFS_B_LATCH_ONLY_SELECT] && !sfr_wdata[SPFS_B_FREE];
  wire logic key_we = sfr_we && sfr_addr == SPFS_SFR_KEY;
  // Counts cycles of one unbroken stall
  always_ff @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || por_i);
  sequence s_arm;
    key_we && sfr_wdata == SPFS_KEY1 ##1 key_we && sfr_wdata == SPFS_KEY2 ##1 wr_go;
  endsequence
  AST_WR_NOPS: assert property (s_arm |=> squash [*2])
    else $error("trigger without two forced slots");
  AST_PROG_STALL: assert property ((s_arm ##0 !quick) |-> ##3 stall)
    else $error("erase or program without stall");
  AST_LOAD_RUN: assert property ((s_arm ##0 quick) |-> ##3 (!stall && !busy_o))
    else $error("latch load stalled");
  AST_STALL_LEN: assert property ($fell(stall) |-> cnt_q == PROG_CYCLES)
    else $error("stall length wrong");
  AST_RESUME: assert property ($fell(stall) |-> (!squash && !busy_o))
    else $error("no resume after stall");
  AST_RD_STEAL: assert property (rd_go |=> (busy_o && !squash) ##1 squash ##1 (!squash && !busy_o))
    else $error("read slot timing wrong");
  AST_RD_HOLD: assert property (!sfr_re |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  AST_TRIG_CLR: assert property (sfr_re && sfr_addr == SPFS_SFR_CTRL |=>
    (sfr_rdata[7] && !sfr_rdata[SPFS_B_WR] && !sfr_rdata[SPFS_B_RD]))
    else $error("trigger bit still set");
  cover property (rd_go);
  cover property (s_arm ##0 quick);
  cover property ($fell(stall));
endmodule

//--- bench/tb_self_program_flash_sequencer.sv
// Bench: CPU end and sequencer joined, plus a sequencer fed broken sequences
`timescale 1ns/100ps
module tb_self_program_flash_sequencer;
  import spfs_pkg::*;
  // ********
  // Signals and instances
  // ********
  localparam int unsigned PC = 20;
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic rst2 = 1'h1;
  logic por_i = 1'h1;
  logic ce = 1'h1;
  logic [2:0] sw_addr = 3'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_we = 1'h0;
  logic sw_re = 1'h0;
  logic [15:0] sw_rdata;
  logic busy, fault, busy2, fault2;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h63E1;
  logic [14:0] base;
  logic [13:0] img [32];
  logic [13:0] lat [32];
  spfs_if link ();
  spfs_if link2 ();
  spfs_device #(.PROG_CYCLES(PC)) u_spfs_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .por_i(por_i), .ce_i(ce), .bus(link), .busy_o(busy), .write_fault_o(fault));
  spfs_device #(.PROG_CYCLES(PC)) u_spfs_device_b (.ref_clk_i(ref_clk_i), .rst_i(rst2),
    .por_i(por_i), .ce_i(ce), .bus(link2), .busy_o(busy2), .write_fault_o(fault2));
  spfs_host u_spfs_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .bus(link),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_we_i(sw_we), .sw_re_i(sw_re),
    .sw_rdata_o(sw_rdata));
  spfs_chk #(.PROG_CYCLES(PC)) u_spfs_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .por_i(por_i), .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata),
    .sfr_we(link.sfr_we), .sfr_re(link.sfr_re), .sfr_rdata(link.sfr_rdata),
    .squash(link.squash), .stall(link.stall), .busy_o(busy));
  // Free-running clock
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ********
  // Helpers
  // ********
  function automatic logic [13:0] merge(input logic [13:0] old, input logic [13:0] nw);
    return old & nw; // programming only clears bits
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Host port write and read
  task automatic hw(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_we <= 1'h1;
    @(posedge ref_clk_i);
    sw_we <= 1'h0;
  endtask
  task automatic hr(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr <= a;
    sw_re <= 1'h1;
    @(posedge ref_clk_i);
    sw_re <= 1'h0;
    #1 d = sw_rdata;
  endtask
  // One host command, polled to completion with a bound
  task automatic op(input logic [1:0] o, input logic [14:0] a, input logic [13:0] d);
    logic [15:0] s;
    hw(SPFS_H_ADDR, {1'h0, a});
    hw(SPFS_H_DATA, {2'h0, d});
    hw(SPFS_H_CMD, {14'h0000, o});
    for (int i = 0; i < 400; i++) begin
      hr(SPFS_H_STAT, s);
      if (s[1] === 1'h1) return;
    end
    fail_count++;
    summarize();
  endtask
  task automatic rdw(input logic [14:0] a, input logic [13:0] e);
    logic [15:0] r;
    op(SPFS_OP_READ, a, 14'h0000);
    hr(SPFS_H_RDATA, r);
    check(r, {2'h0, e});
  endtask
  task automatic erase();
    logic [31:0] r;
    r = $random(seed);
    op(SPFS_OP_ERASE, {base[14:5], r[4:0]}, r[13:0]);
    for (int i = 0; i < 32; i++) begin
      img[i] = SPFS_BLANK;
      lat[i] = SPFS_BLANK;
    end
  endtask
  // Direct access to the second sequencer
  task automatic dw(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    link2.sfr_addr <= a;
    link2.sfr_wdata <= d;
    link2.sfr_we <= 1'h1;
    @(posedge ref_clk_i);
    link2.sfr_we <= 1'h0;
    link2.sfr_wdata <= ~d;
    #1;
  endtask
  task automatic dr(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    link2.sfr_addr <= a;
    link2.sfr_re <= 1'h1;
    @(posedge ref_clk_i);
    link2.sfr_re <= 1'h0;
    #1 d = link2.sfr_rdata;
  endtask
  task automatic try(input logic [2:0] a, input logic [7:0] k1, input logic [7:0] k2,
      input logic [7:0] c, input logic sq, input logic bz);
    dw(a, k1);
    dw(SPFS_SFR_KEY, k2);
    dw(SPFS_SFR_CTRL, c);
    check(16'(link2.squash), 16'(sq));
    @(posedge ref_clk_i);
    #1 check(16'(link2.squash), 16'(sq));
    @(posedge ref_clk_i);
    #1 check(16'(busy2), 16'(bz));
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    logic [31:0] r;
    logic [7:0] v;
    int n;
    link2.sfr_addr = 3'h0;
    link2.sfr_wdata = 8'h00;
    link2.sfr_we = 1'h0;
    link2.sfr_re = 1'h0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    rst2 <= 1'h0;
    por_i <= 1'h0;
    r = $random(seed);
    base = {r[14:5], 5'h00};
    for (int k = 0; k < 3; k++) begin
      if (k == 0) begin
        erase();
      end
      n = 1 + ({$random(seed)} % 31);
      for (int i = 0; i < n; i++) begin
        r = $random(seed);
        op(SPFS_OP_LOAD, {base[14:5], r[4:0]}, r[18:5]);
        lat[r[4:0]] = r[18:5];
      end
      if (k == 2) begin
        erase();
      end
      r = $random(seed);
      op(SPFS_OP_PROG, {base[14:5], r[4:0]}, r[18:5]);
      lat[r[4:0]] = r[18:5];
      for (int i = 0; i < 32; i++) begin
        img[i] = merge(img[i], lat[i]);
        lat[i] = SPFS_BLANK;
        rdw({base[14:5], 5'(i)}, img[i]);
      end
    end
    check(16'(fault), 16'h0000);
    try(SPFS_SFR_KEY, SPFS_KEY1, SPFS_KEY2, 8'h26, 1'h1, 1'h0);
    try(SPFS_SFR_KEY, SPFS_KEY2, SPFS_KEY1, 8'h26, 1'h0, 1'h0);
    try(SPFS_SFR_KEY, SPFS_KEY1, SPFS_KEY1, 8'h26, 1'h0, 1'h0);
    try(SPFS_SFR_KEY, SPFS_KEY1, SPFS_KEY2, 8'h22, 1'h0, 1'h0);
    dw(SPFS_SFR_KEY, SPFS_KEY1);
    try(SPFS_SFR_DATA_LO, 8'h5A, SPFS_KEY2, 8'h26, 1'h0, 1'h0);
    dr(SPFS_SFR_CTRL, v);
    check(16'(v[SPFS_B_WR]), 16'h0000);
    try(SPFS_SFR_KEY, SPFS_KEY1, SPFS_KEY2, 8'h06, 1'h1, 1'h1);
    // Clock enable low freezes the self-timed count mid-operation
    @(posedge ref_clk_i);
    ce <= 1'h0;
    repeat (30) @(posedge ref_clk_i);
    #1 check(16'(busy2), 16'h0001);
    check(16'(link2.stall), 16'h0001);
    @(posedge ref_clk_i);
    ce <= 1'h1;
    rst2 <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    rst2 <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #1 check(16'(fault2), 16'h0001);
    dr(SPFS_SFR_KEY, v);
    check(16'(v), 16'h0000);
    dr(SPFS_SFR_CTRL, v);
    check(16'(v), 16'h0088);
    @(posedge ref_clk_i);
    por_i <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    por_i <= 1'h0;
    dr(SPFS_SFR_CTRL, v);
    check(16'(v), 16'h0080);
    summarize();
  end
endmodule
